/* File: csb_top.sv */
// Clock source, safeguard, backup oscillator, reset delay and clock dividers with an APB slave.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none

module csb_top
  import csb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire csb_apb_req_t apb_req,
  output csb_apb_rsp_t apb_rsp,
  input wire logic main_osc_in,
  input wire logic vdd_low,
  input wire logic safeguard_enable_option,
  output logic main_osc_enable,
  output logic backup_osc_on,
  output logic on_backup,
  output logic por_done,
  output logic [7:0] converter_ctrl,
  output csb_ticks_t ticks
);

  localparam int FW = $clog2(FILTER_CYC + 1);
  localparam int MW = $clog2(MISS_CYC + 1);
  localparam int BW = $clog2(BACKUP_CYC + 1);
  localparam int LW = $clog2(LIMIT_CYC + 1);
  localparam int SW = $clog2(MAIN_START_EDGES + 1);
  localparam int RW = $clog2(RESET_DELAY_CYCLES + 1);
  localparam logic [FW-1:0] FILTER_LAST = FW'(FILTER_CYC - 1);
  localparam logic [MW-1:0] MISS_LAST = MW'(MISS_CYC);
  localparam logic [BW-1:0] BACKUP_LAST = BW'(BACKUP_CYC - 1);
  localparam logic [LW-1:0] LIMIT_LAST = LW'(LIMIT_CYC);
  localparam logic [SW-1:0] START_LAST = SW'(MAIN_START_EDGES);
  localparam logic [RW-1:0] DELAY_LAST = RW'(RESET_DELAY_CYCLES);

  // All state of the block.
  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic vdd_s1;
    logic vdd_s2;
    logic opt_s1;
    logic opt_s2;
    logic [1:0] opt_wait;
    logic opt_taken;
    logic opt;
    logic osc_level;
    logic [FW-1:0] flt_cnt;
    logic [MW-1:0] miss_cnt;
    logic [LW-1:0] gap_cnt;
    logic [SW-1:0] start_cnt;
    logic main_ok;
    logic main_tick;
    logic backup_on;
    logic [BW-1:0] bk_cnt;
    logic backup_tick;
    logic [RW-1:0] delay_cnt;
    logic por_done;
    logic osc_en;
    logic [7:0] conv_ctrl;
    logic [7:0] clk_cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } csb_top_st_t;

  csb_top_st_t st_r;
  csb_top_st_t st_nxt;

  logic int_tick;
  logic sel_backup;
  logic periph_tick;
  logic cpu_tick;
  logic art_tick;
  logic [3:0] art_ratio;
  logic osc_off_eff;
  logic limit_on;

  // Reads the register at a word index, with a hit flag in the top bit.
  function automatic logic [8:0] csb_read(input logic [9:0] idx, input csb_top_st_t s,
                                          input logic sel_bk);
    logic [7:0] stat;
    stat = 8'h00;
    stat[STAT_MAIN_OK_BIT] = s.main_ok;
    stat[STAT_BACKUP_ON_BIT] = s.backup_on;
    stat[STAT_ON_BACKUP_BIT] = sel_bk;
    stat[STAT_POR_DONE_BIT] = s.por_done;
    stat[STAT_OPTION_BIT] = s.opt;
    stat[STAT_LIMIT_BIT] = s.opt & s.vdd_s2;
    case (idx)
      IDX_CONV_CTRL: csb_read = {1'b1, s.conv_ctrl};
      IDX_CLK_CFG: csb_read = {1'b1, s.clk_cfg};
      IDX_CLK_STAT: csb_read = {1'b1, stat};
      default: csb_read = 9'h000;
    endcase
  endfunction : csb_read

  // The disable bit only acts when the safeguard option is strapped on.
  assign osc_off_eff = st_r.opt & st_r.conv_ctrl[OSC_OFF_BIT];
  assign limit_on = st_r.opt & st_r.vdd_s2;
  assign art_ratio = st_r.clk_cfg[CFG_ART_SLOW_BIT] ? DIV_ART_SLOW : DIV_ART_FAST;

  // Main combinational update of the whole block state.
  always_comb begin
    logic [8:0] rd;
    logic [9:0] idx;
    logic setup;
    logic access;
    logic edge_now;
    rd = 9'h000;
    edge_now = 1'b0;
    idx = apb_req.paddr[11:2];
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable & st_r.pready;
    st_nxt = st_r;

    // Two-flop synchronisers for the pins and the strap.
    st_nxt.osc_s1 = main_osc_in;
    st_nxt.osc_s2 = st_r.osc_s1;
    st_nxt.vdd_s1 = vdd_low;
    st_nxt.vdd_s2 = st_r.vdd_s1;
    st_nxt.opt_s1 = safeguard_enable_option;
    st_nxt.opt_s2 = st_r.opt_s1;

    // The strap is caught once, after it has passed the synchroniser.
    if (!st_r.opt_taken) begin
      if (st_r.opt_wait == 2'h2) begin
        st_nxt.opt = st_r.opt_s2;
        st_nxt.opt_taken = 1'b1;
      end else begin
        st_nxt.opt_wait = st_r.opt_wait + 2'h1;
      end
    end

    // Spike filter: a new level counts only after it has stood long enough.
    if (!st_r.opt) begin
      st_nxt.osc_level = st_r.osc_s2;
      st_nxt.flt_cnt = '0;
    end else if (st_r.osc_s2 == st_r.osc_level) begin
      st_nxt.flt_cnt = '0;
    end else if (st_r.flt_cnt >= FILTER_LAST) begin
      st_nxt.osc_level = st_r.osc_s2;
      st_nxt.flt_cnt = '0;
    end else begin
      st_nxt.flt_cnt = st_r.flt_cnt + FW'(1);
    end

    // Rising edge of the accepted level.
    edge_now = st_nxt.osc_level & ~st_r.osc_level;

    // Missing edge watch; a disabled main counts as dead at once.
    if (edge_now && !osc_off_eff) begin
      st_nxt.miss_cnt = '0;
    end else if (osc_off_eff) begin
      st_nxt.miss_cnt = MISS_LAST;
    end else if (st_r.miss_cnt < MISS_LAST) begin
      st_nxt.miss_cnt = st_r.miss_cnt + MW'(1);
    end

    // Frequency cap: edges too close to the previous accepted one are dropped.
    st_nxt.main_tick = 1'b0;
    if (st_r.gap_cnt < LIMIT_LAST) begin
      st_nxt.gap_cnt = st_r.gap_cnt + LW'(1);
    end
    if (edge_now && !osc_off_eff) begin
      if (!limit_on || st_r.gap_cnt >= LIMIT_LAST) begin
        st_nxt.main_tick = 1'b1;
        st_nxt.gap_cnt = '0;
      end
    end

    // The main is running after enough good edges; only the safeguard watches for a failure.
    if (st_r.opt && st_r.miss_cnt >= MISS_LAST) begin
      st_nxt.start_cnt = '0;
      st_nxt.main_ok = 1'b0;
    end else if (st_nxt.main_tick && st_r.start_cnt < START_LAST) begin
      st_nxt.start_cnt = st_r.start_cnt + SW'(1);
    end else if (st_r.start_cnt >= START_LAST) begin
      st_nxt.main_ok = 1'b1;
    end

    // Backup runs only with the option strapped and only while the main is not running.
    st_nxt.backup_on = st_r.opt & st_r.opt_taken & ~st_r.main_ok;
    st_nxt.backup_tick = 1'b0;
    if (!st_r.backup_on) begin
      st_nxt.bk_cnt = '0;
    end else if (st_r.bk_cnt >= BACKUP_LAST) begin
      st_nxt.bk_cnt = '0;
      st_nxt.backup_tick = 1'b1;
    end else begin
      st_nxt.bk_cnt = st_r.bk_cnt + BW'(1);
    end

    // Reset delay counts internal clock edges, whichever source supplies them.
    if (int_tick && !st_r.por_done) begin
      if ((st_r.delay_cnt + RW'(1)) >= DELAY_LAST) begin
        st_nxt.por_done = 1'b1;
      end
      st_nxt.delay_cnt = st_r.delay_cnt + RW'(1);
    end

    // Main oscillator drive enable.
    st_nxt.osc_en = ~osc_off_eff;

    // APB slave: answer is prepared in the setup cycle, ready in the access cycle.
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (setup) begin
      rd = csb_read(idx, st_r, sel_backup);
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = ~rd[8];
      st_nxt.prdata = apb_req.pwrite ? 32'h00000000 : {24'h000000, rd[7:0]};
    end
    if (access && apb_req.pwrite) begin
      if (idx == IDX_CONV_CTRL) begin
        st_nxt.conv_ctrl = apb_req.pwdata[7:0];
      end else if (idx == IDX_CLK_CFG) begin
        st_nxt.clk_cfg = {7'h00, apb_req.pwdata[CFG_ART_SLOW_BIT]};
      end
    end
  end

  // Registers the block state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.conv_ctrl <= CONV_CTRL_RESET;
      st_r.clk_cfg <= CLK_CFG_RESET;
      st_r.osc_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Source selection; the whole system follows the selected stream unchanged.
  csb_clk_sel u_sel (
    .pclk(pclk),
    .presetn(presetn),
    .main_tick(st_r.main_tick),
    .backup_tick(st_r.backup_tick),
    .want_backup(~st_r.main_ok),
    .int_tick(int_tick),
    .on_backup(sel_backup)
  );

  // Divider for the timer, watchdog and converter.
  csb_div #(.W(4)) u_div_periph (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(int_tick),
    .ratio(DIV_PERIPH),
    .tick_out(periph_tick)
  );

  // Divider for the core and the serial interface.
  csb_div #(.W(4)) u_div_cpu (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(int_tick),
    .ratio(DIV_CPU),
    .tick_out(cpu_tick)
  );

  // Divider for the auto-reload timer.
  csb_div #(.W(4)) u_div_art (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(int_tick),
    .ratio(art_ratio),
    .tick_out(art_tick)
  );

  // Outputs come from flip-flops of this block or of its instances.
  assign apb_rsp.prdata = st_r.prdata;
  assign apb_rsp.pready = st_r.pready;
  assign apb_rsp.pslverr = st_r.pslverr;
  assign main_osc_enable = st_r.osc_en;
  assign backup_osc_on = st_r.backup_on;
  assign on_backup = sel_backup;
  assign por_done = st_r.por_done;
  assign converter_ctrl = st_r.conv_ctrl;
  assign ticks.int_tick = int_tick;
  assign ticks.periph_tick = periph_tick;
  assign ticks.cpu_tick = cpu_tick;
  assign ticks.art_tick = art_tick;

endmodule : csb_top
`default_nettype wire

/* File: csb_pkg.sv */
// Package with constants and carrier types for the clock source and backup oscillator block.
package csb_pkg;

  // Clock rate of pclk in picoseconds per period.
  localparam int PCLK_PERIOD_PS = 5000;

  // Least stable time of the main oscillator line before a level is accepted.
  localparam int FILTER_NS = 20;
  localparam int FILTER_CYC_RAW = (FILTER_NS * 1000 + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS;
  localparam int FILTER_CYC = (FILTER_CYC_RAW < 1) ? 1 : FILTER_CYC_RAW;

  // Time without a main oscillator edge after which the main oscillator counts as failed.
  localparam int MISS_NS = 1000;
  localparam int MISS_CYC_RAW = (MISS_NS * 1000 + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS;
  localparam int MISS_CYC = (MISS_CYC_RAW < 1) ? 1 : MISS_CYC_RAW;

  // Period of the backup low frequency oscillator.
  localparam int BACKUP_PERIOD_NS = 2000;
  localparam int BACKUP_CYC_RAW = (BACKUP_PERIOD_NS * 1000) / PCLK_PERIOD_PS;
  localparam int BACKUP_CYC = (BACKUP_CYC_RAW < 1) ? 1 : BACKUP_CYC_RAW;

  // Least spacing of internal clock edges while the supply is low and the safeguard is on.
  localparam int LIMIT_NS = 250;
  localparam int LIMIT_CYC_RAW = (LIMIT_NS * 1000 + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS;
  localparam int LIMIT_CYC = (LIMIT_CYC_RAW < 1) ? 1 : LIMIT_CYC_RAW;

  // Reset delay length in internal clock cycles, and good edges needed to call the main running.
  localparam int RESET_DELAY_CYCLES = 2048;
  localparam int MAIN_START_EDGES = 16;

  // Fixed divider ratios of the internal clock.
  localparam logic [3:0] DIV_PERIPH = 4'hc;
  localparam logic [3:0] DIV_CPU = 4'hd;
  localparam logic [3:0] DIV_ART_FAST = 4'h1;
  localparam logic [3:0] DIV_ART_SLOW = 4'h3;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_CONV_CTRL = 10'h0d1;
  localparam logic [9:0] IDX_CLK_CFG = 10'h0d2;
  localparam logic [9:0] IDX_CLK_STAT = 10'h0d3;

  // Reset values and field positions.
  localparam logic [7:0] CONV_CTRL_RESET = 8'h40;
  localparam logic [7:0] CLK_CFG_RESET = 8'h00;
  localparam int OSC_OFF_BIT = 2;
  localparam int CFG_ART_SLOW_BIT = 0;
  localparam int STAT_MAIN_OK_BIT = 0;
  localparam int STAT_BACKUP_ON_BIT = 1;
  localparam int STAT_ON_BACKUP_BIT = 2;
  localparam int STAT_POR_DONE_BIT = 3;
  localparam int STAT_OPTION_BIT = 4;
  localparam int STAT_LIMIT_BIT = 5;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } csb_apb_req_t;

  // APB answer to the master.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } csb_apb_rsp_t;

  // One-cycle ticks of the derived clocks.
  typedef struct packed {
    logic int_tick;
    logic periph_tick;
    logic cpu_tick;
    logic art_tick;
  } csb_ticks_t;

endpackage : csb_pkg

/* File: csb_div.sv */
// Tick divider that passes one input tick out of every ratio ticks.
`timescale 1ns/1ps
`default_nettype none
module csb_div
  import csb_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  input wire logic [W-1:0] ratio,
  output logic tick_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic out;
  } csb_div_st_t;

  csb_div_st_t st_r;
  csb_div_st_t st_nxt;

  // Refuse widths that cannot hold the largest fixed ratio.
  initial begin
    if (W < 4) begin
      $error("csb_div width too small");
    end
  end

  // Counts input ticks and emits a tick on the last one of each group.
  always_comb begin
    st_nxt = st_r;
    st_nxt.out = 1'b0;
    if (tick_in) begin
      if ((st_r.cnt + {{(W-1){1'b0}}, 1'b1}) >= ratio) begin
        st_nxt.cnt = '0;
        st_nxt.out = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Registers the divider state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.out;

endmodule : csb_div
`default_nettype wire

/* File: csb_clk_sel.sv */
// Glitch-free selector between the main and backup oscillator tick streams.
`timescale 1ns/1ps
`default_nettype none
module csb_clk_sel
  import csb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic main_tick,
  input wire logic backup_tick,
  input wire logic want_backup,
  output logic int_tick,
  output logic on_backup
);

  typedef struct packed {
    logic sel;
    logic tick;
  } csb_sel_st_t;

  csb_sel_st_t st_r;
  csb_sel_st_t st_nxt;

  // The source changes only in a cycle with no tick on either stream, so no pulse is cut.
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = st_r.sel ? backup_tick : main_tick;
    if ((want_backup != st_r.sel) && !main_tick && !backup_tick) begin
      st_nxt.sel = want_backup;
    end
  end

  // Registers the selector state; reset starts on the backup stream.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{sel: 1'b1, tick: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign int_tick = st_r.tick;
  assign on_backup = st_r.sel;

endmodule : csb_clk_sel
`default_nettype wire

/* File: csb_osc_model.sv */
// Behavioural main oscillator that the block powers and watches.
`timescale 1ns/1ps
`default_nettype none
module csb_osc_model #(
  parameter int HALF = 10
) (
  input wire logic pclk,
  input wire logic enable,
  input wire logic run,
  input wire logic spike,
  output logic osc_out
);
  int cnt = 0;
  logic lvl = 1'b0;
  // Toggles every HALF cycles while powered and healthy, else the line sits low.
  always @(posedge pclk) begin
    if (!(enable && run)) begin
      lvl <= 1'b0;
      cnt <= 0;
    end else if (cnt >= HALF - 1) begin
      lvl <= ~lvl;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // A spike flips the line for as long as it is held.
  assign osc_out = lvl ^ spike;
endmodule : csb_osc_model
`default_nettype wire

/* File: csb_top_assertions.sv */
// Port checker of the clock source block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module csb_top_chk
  import csb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire csb_apb_req_t apb_req,
  input wire csb_apb_rsp_t apb_rsp,
  input wire logic main_osc_in,
  input wire logic vdd_low,
  input wire logic safeguard_enable_option,
  input wire logic main_osc_enable,
  input wire logic backup_osc_on,
  input wire logic on_backup,
  input wire logic por_done,
  input wire logic [7:0] converter_ctrl,
  input wire csb_ticks_t ticks
);
  localparam int BK_LO = BACKUP_CYC - 5;
  localparam int BK_HI = BACKUP_CYC + 10;
  logic [3:0] per_cnt;
  logic per_seen;
  logic [11:0] por_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counts internal ticks per peripheral period and since reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt <= 4'h0;
      per_seen <= 1'b0;
      por_cnt <= 12'h000;
    end else begin
      if (ticks.periph_tick) begin
        per_cnt <= 4'h0;
        per_seen <= 1'b1;
      end else if (ticks.int_tick) begin
        per_cnt <= per_cnt + 4'h1;
      end
      if (ticks.int_tick && por_cnt != 12'hfff) begin
        por_cnt <= por_cnt + 12'h001;
      end
    end
  end
  chk_periph_ratio: assert property (per_seen && ticks.periph_tick |->
    (per_cnt + 4'(ticks.int_tick)) == DIV_PERIPH) else $error("periph ratio wrong");
  chk_por_length: assert property ($rose(por_done) |->
    por_cnt == RESET_DELAY_CYCLES) else $error("reset delay length wrong");
  chk_backup_period: assert property ($rose(backup_osc_on) && on_backup |->
    ##[BK_LO:BK_HI] ticks.int_tick) else $error("first backup tick late");
  chk_backup_option: assert property (!safeguard_enable_option |->
    !backup_osc_on) else $error("backup without option");
  chk_disable_gated: assert property (!safeguard_enable_option |->
    main_osc_enable) else $error("main disabled without option");
  chk_disable_bit: assert property ((safeguard_enable_option &&
    converter_ctrl[OSC_OFF_BIT]) [*4] |-> !main_osc_enable) else $error("main not off");
  chk_enable_bit: assert property (!converter_ctrl[OSC_OFF_BIT] [*4] |->
    main_osc_enable) else $error("main not on");
  chk_backup_off: assert property ($fell(on_backup) |->
    ##[0:8] !backup_osc_on) else $error("backup left on");
  chk_backup_start: assert property ($fell(main_osc_enable) |->
    ##[0:20] backup_osc_on) else $error("backup not started");
  chk_tick_spacing: assert property (ticks.int_tick |=>
    !ticks.int_tick) else $error("internal tick cut short");
  cov_to_backup: cover property ($rose(on_backup));
  cov_to_main: cover property ($fell(on_backup));
  cov_por: cover property ($rose(por_done));
endmodule : csb_top_chk
bind csb_top csb_top_chk u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .main_osc_in(main_osc_in), .vdd_low(vdd_low),
  .safeguard_enable_option(safeguard_enable_option), .main_osc_enable(main_osc_enable),
  .backup_osc_on(backup_osc_on), .on_backup(on_backup), .por_done(por_done),
  .converter_ctrl(converter_ctrl), .ticks(ticks));
`default_nettype wire

/* File: csb_top_tb.sv */
// Self-checking testbench of the clock source block.
`timescale 1ns/1ps
`default_nettype none
module csb_top_tb
  import csb_pkg::*;
;
  localparam int HALF = 10;
  localparam int B_INT = 3;
  localparam int B_MEN = 4;
  localparam int B_BKON = 5;
  localparam int B_ONBK = 6;
  localparam int B_POR = 7;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic opt = 1'b1;
  logic vdd = 1'b0;
  logic run = 1'b0;
  logic spike = 1'b0;
  logic osc, men, bkon, onbk, por, err;
  csb_apb_req_t req = '0;
  csb_apb_rsp_t rsp;
  logic [7:0] conv;
  csb_ticks_t tk;
  logic [7:0] mon;
  logic [31:0] rd;
  int num_errors = 0;
  int n_tests = 0;
  int por_at = 0;
  int tick_cnt = 0;
  int n;
  // Clock and a view of the outputs by bit index.
  always #2.5 pclk = ~pclk;
  assign mon = {por, onbk, bkon, men, tk};
  csb_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .main_osc_in(osc),
    .vdd_low(vdd), .safeguard_enable_option(opt), .main_osc_enable(men), .backup_osc_on(bkon),
    .on_backup(onbk), .por_done(por), .converter_ctrl(conv), .ticks(tk));
  csb_osc_model #(.HALF(HALF)) u_osc (.pclk(pclk), .enable(men), .run(run), .spike(spike),
    .osc_out(osc));
  // Counts internal ticks from reset and notes the count when the delay ends.
  always @(posedge pclk) begin
    if (!presetn) tick_cnt <= 0;
    else if (tk.int_tick) tick_cnt <= tick_cnt + 1;
    if (por && por_at == 0) por_at <= tick_cnt;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_for(input int b, input logic v, input int lim);
    n = 0;
    while (mon[b] !== v) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        check("wait", b, 99);
        print_verdict();
      end
    end
  endtask : wait_for
  // Cycles between two ticks of one kind, with a short spike in between if asked.
  task automatic gap(input int b, input bit spk, output int c);
    wait_for(b, 1'b1, 2000);
    @(posedge pclk);
    if (spk) begin
      repeat (4) @(posedge pclk);
      spike <= 1'b1;
      @(posedge pclk);
      spike <= 1'b0;
    end
    wait_for(b, 1'b1, 2000);
    c = n + 1 + (spk ? 5 : 0);
  endtask : gap
  task automatic ratio(input int b, input int exp);
    int k;
    int j;
    k = 0;
    j = 0;
    wait_for(b, 1'b1, 9000);
    do begin
      @(posedge pclk);
      j++;
      if (mon[B_INT] === 1'b1) k++;
    end while (mon[b] !== 1'b1 && k < 20 && j < 9000);
    check("ratio", k, exp);
  endtask : ratio
  task automatic apb(input bit wr, input logic [9:0] idx, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 16);
    if (rsp.pready !== 1'b1) begin
      check("pready", 0, 1);
      print_verdict();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic reg_rd(input logic [9:0] idx, input logic [32:0] exp);
    apb(1'b0, idx, 32'h0);
    check("read", {err, rd}, exp);
  endtask : reg_rd
  task automatic t_reset;
    repeat (5) @(posedge pclk);
    check("reset_outs", mon, 8'h50); // Main enabled at reset
    check("reset_conv", conv, 8'h40); // Reset value
    presetn <= 1'b1;
    reg_rd(IDX_CONV_CTRL, 33'h40); // Reset value
    reg_rd(IDX_CLK_CFG, 33'h0); // Fast timer at reset
    reg_rd(10'h0d7, 33'h100000000);
  endtask : t_reset
  task automatic t_power_up;
    int c;
    wait_for(B_BKON, 1'b1, 20); // Backup runs
    check("on_backup", onbk, 1'b1); // Backup clocks the delay
    gap(B_INT, 1'b0, c);
    check("backup_gap", c, BACKUP_CYC); // Backup period
    run <= 1'b1;
    wait_for(B_ONBK, 1'b0, 2000); // Main takes over
    wait_for(B_BKON, 1'b0, 20); // Backup stops
    check("por_early", por, 1'b0); // Delay still running
    wait_for(B_POR, 1'b1, 60000); // Delay ends
    @(posedge pclk);
    check("por_count", por_at, RESET_DELAY_CYCLES); // Delay length
    reg_rd(IDX_CLK_STAT, 33'h19); // Main runs, backup off
  endtask : t_power_up
  task automatic t_dividers;
    ratio(2, DIV_PERIPH); // Peripheral tick
    ratio(1, DIV_CPU); // Core tick
    ratio(0, DIV_ART_FAST); // Fast timer tick
    apb(1'b1, IDX_CLK_CFG, 32'h1); // Select slow timer
    ratio(0, DIV_ART_SLOW); // Slow timer tick
  endtask : t_dividers
  task automatic t_spike_limit;
    int c;
    gap(B_INT, 1'b1, c);
    check("spike_gap", c, 2 * HALF); // Spike dropped
    vdd <= 1'b1;
    gap(B_INT, 1'b0, c);
    gap(B_INT, 1'b0, c);
    check("limited", c >= LIMIT_CYC, 1'b1); // Rate capped
    vdd <= 1'b0;
    gap(B_INT, 1'b0, c);
    gap(B_INT, 1'b0, c);
    check("free", c, 2 * HALF); // Cap lifted
  endtask : t_spike_limit
  task automatic t_disable;
    int c;
    apb(1'b1, IDX_CONV_CTRL, 32'h44); // Disable main
    wait_for(B_MEN, 1'b0, 8); // Main off
    wait_for(B_ONBK, 1'b1, 1000); // Backup selected
    gap(B_INT, 1'b0, c);
    check("backup_run", c, BACKUP_CYC); // Keeps running
    reg_rd(IDX_CONV_CTRL, 33'h44); // Stored as written
    apb(1'b1, IDX_CONV_CTRL, 32'hfb); // Enable main
    wait_for(B_MEN, 1'b1, 8); // Other bits inert
    wait_for(B_ONBK, 1'b0, 2000); // Main back
    reg_rd(IDX_CONV_CTRL, 33'hfb); // Stored as written
    check("conv_out", conv, 8'hfb); // Converter bits passed on
  endtask : t_disable
  task automatic t_fail;
    wait_for(B_INT, 1'b1, 200);
    run <= 1'b0;
    wait_for(B_BKON, 1'b1, MISS_CYC + 20);
    check("miss_time", n > MISS_CYC - 20, 1'b1); // Missing edge
    wait_for(B_ONBK, 1'b1, 600); // Switchover
    run <= 1'b1;
    wait_for(B_ONBK, 1'b0, 3000); // Main back
  endtask : t_fail
  task automatic t_no_option;
    opt <= 1'b0;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, IDX_CONV_CTRL, 32'h04);
    wait_for(B_ONBK, 1'b0, 2000);
    check("men_kept", men, 1'b1); // Bit ignored
    run <= 1'b0;
    repeat (MISS_CYC + BACKUP_CYC) @(posedge pclk);
    check("no_backup", {bkon, onbk}, 2'b00); // No backup
  endtask : t_no_option
  // Main sequence.
  initial begin
    t_reset();
    t_power_up();
    t_dividers();
    t_spike_limit();
    t_disable();
    t_fail();
    t_no_option();
    print_verdict();
  end
endmodule : csb_top_tb
`default_nettype wire
